// ===== bcr1_pkg.sv
// Package for the board control register one block: offsets, field positions, reset values
package bcr1_pkg;
    // Register selection within the board register window
    localparam logic [2:0] BCR1_REG_INDEX = 3'h1;
    localparam logic [4:0] BCR1_BYTE_OFFSET = 5'h04;
    localparam int BCR1_ADDR_W = 3;
    localparam int BCR1_DATA_W = 32;
    // Field positions, big-endian numbering (bit 0 is data[31])
    localparam int BCR1_POS_CFG_SRC = 0;
    localparam int BCR1_POS_BOOT_SWAP = 1;
    localparam int BCR1_POS_CELL_EN = 2;
    localparam int BCR1_POS_CELL_RST = 3;
    localparam int BCR1_POS_PHY_IEN = 4;
    localparam int BCR1_POS_PHY_RST = 5;
    localparam int BCR1_POS_SER_A_EN = 6;
    localparam int BCR1_POS_SER_B_EN = 7;
    localparam int BCR1_CTRL_W = 6;
    // Reset value of the six writable fields, bits 2..7
    localparam logic [5:0] BCR1_CTRL_RESET = 6'h3f;
    // Bus access kinds
    typedef enum logic [1:0] {BCR1_IDLE, BCR1_READ, BCR1_WRITE} bcr1_access_t;
endpackage

// ===== bcr1_ctrl_store.sv
// Writable control field storage of board control register one
`timescale 1ns/1ps
module bcr1_ctrl_store
    import bcr1_pkg::*;
#(
    parameter int WIDTH = BCR1_CTRL_W
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    initial
    begin
        if (WIDTH != BCR1_CTRL_W)
        begin
            $error("bcr1_ctrl_store: WIDTH must match the control field count");
        end
    end

    // Next value: power-on defaults, then software writes
    always_comb
    begin
        q_nxt = q_r;
        if (sys_rst)
        begin
            q_nxt = BCR1_CTRL_RESET[WIDTH-1:0]; // [R03]
        end
        else if (wr_en)
        begin
            q_nxt = wr_data;
        end
    end

    // Register the fields
    always_ff @(posedge clk)
    begin
        q_r <= q_nxt;
    end

    assign q = q_r;
endmodule

// ===== bcr1_top.sv
// Board control register one: jumper status, transceiver enables and resets
//
// Summary of operation
// R01: Register answers at offset 4, read/write.
// R02: No access while window disabled.
// R03: Writable fields load defaults at power-on.
// R04: Bit 0 reflects config source jumper.
// R05: Bit 1 reflects boot select swap jumper.
// R06: Bit 2 drives cell transceiver enable, default 1.
// R07: Bit 3 cell reset, also forced by host.
// R08: Bit 4 drives PHY initial enable, default 1.
// R09: Software later isolates PHY via management bit.
// R10: Bit 5 PHY reset, also forced by host.
// R11: PHY reset release hands control to management.
// R12: Bit 6 drives serial A transceiver enable.
// R13: Bit 7 drives serial B transceiver enable.
// R14: Only three address lines decoded; register repeats.
// R15: Bits 8 to 31 read zero, ignore writes.
// R16: Bit 0 is the data word MSB.
`timescale 1ns/1ps
module bcr1_top
    import bcr1_pkg::*;
#(
    parameter int ADDR_W = BCR1_ADDR_W,
    parameter int DATA_W = BCR1_DATA_W
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic window_cs_n,
    input wire logic window_disable,
    input wire logic bus_we,
    input wire logic bus_re,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    output logic [DATA_W-1:0] bus_rdata,
    output logic bus_ack,
    input wire logic config_source_jumper,
    input wire logic boot_select_swap,
    input wire logic host_hard_reset_n,
    output logic cell_xcvr_enable_n,
    output logic cell_xcvr_reset_n,
    output logic phy_initial_enable_n,
    output logic phy_reset_n,
    output logic serial_a_xcvr_enable_n,
    output logic serial_b_xcvr_enable_n
);
    import bcr1_pkg::*;

    initial
    begin
        if (ADDR_W != BCR1_ADDR_W || DATA_W != BCR1_DATA_W)
        begin
            $error("bcr1_top: only three address lines and 32 data bits are served");
        end
    end

    // Big-endian bit n sits at data index DATA_W-1-n
    function automatic int be_idx(input int n);
        return DATA_W - 1 - n; // [R16]
    endfunction

    // Pin synchronisers for jumpers and host reset
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync1_nxt;
    logic [2:0] sync2_nxt;

    always_comb
    begin
        sync1_nxt = {host_hard_reset_n, boot_select_swap, config_source_jumper};
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge clk)
    begin
        sync1_r <= sync1_nxt;
        sync2_r <= sync2_nxt;
    end

    logic cfg_src_s;
    logic boot_swap_s;
    logic host_rst_n_s;
    assign cfg_src_s = sync2_r[0];
    assign boot_swap_s = sync2_r[1];
    assign host_rst_n_s = sync2_r[2];

    // Access decode: three address lines only, so the register repeats
    bcr1_access_t acc;
    logic sel;
    always_comb
    begin
        sel = !window_cs_n && !window_disable && (bus_addr == BCR1_REG_INDEX); // [R01] [R02] [R14]
        if (sel && bus_we)
        begin
            acc = BCR1_WRITE;
        end
        else if (sel && bus_re)
        begin
            acc = BCR1_READ;
        end
        else
        begin
            acc = BCR1_IDLE;
        end
    end

    // Writable fields, bits 2..7, packed with bit 2 at index 5
    logic [BCR1_CTRL_W-1:0] ctrl_wdata;
    logic [BCR1_CTRL_W-1:0] ctrl_q;
    always_comb
    begin
        ctrl_wdata = '0;
        for (int i = 0; i < BCR1_CTRL_W; i++)
        begin
            ctrl_wdata[BCR1_CTRL_W-1-i] = bus_wdata[be_idx(BCR1_POS_CELL_EN + i)]; // [R15] upper bits dropped
        end
    end

    bcr1_ctrl_store #(
        .WIDTH(BCR1_CTRL_W)
    ) u_store (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(acc == BCR1_WRITE),
        .wr_data(ctrl_wdata),
        .q(ctrl_q)
    );

    function automatic logic field(input int pos);
        return ctrl_q[BCR1_CTRL_W-1-(pos-BCR1_POS_CELL_EN)];
    endfunction

    // Bus answer and pin drive registers
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [5:0] pins_r;
    logic [5:0] pins_nxt;

    always_comb
    begin
        rdata_nxt = rdata_r;
        ack_nxt = 1'b0;
        if (acc != BCR1_IDLE)
        begin
            ack_nxt = 1'b1;
        end
        if (acc == BCR1_READ)
        begin
            rdata_nxt = '0; // [R15]
            rdata_nxt[be_idx(BCR1_POS_CFG_SRC)] = cfg_src_s; // [R04]
            rdata_nxt[be_idx(BCR1_POS_BOOT_SWAP)] = boot_swap_s; // [R05]
            for (int i = 0; i < BCR1_CTRL_W; i++)
            begin
                rdata_nxt[be_idx(BCR1_POS_CELL_EN + i)] = ctrl_q[BCR1_CTRL_W-1-i];
            end
        end
        pins_nxt[0] = field(BCR1_POS_CELL_EN); // [R06]
        pins_nxt[1] = field(BCR1_POS_CELL_RST) & host_rst_n_s; // [R07]
        pins_nxt[2] = field(BCR1_POS_PHY_IEN); // [R08]
        // Reset release lets the PHY sample its straps
        pins_nxt[3] = field(BCR1_POS_PHY_RST) & host_rst_n_s; // [R10] [R11]
        pins_nxt[4] = field(BCR1_POS_SER_A_EN); // [R12]
        pins_nxt[5] = field(BCR1_POS_SER_B_EN); // [R13]
        if (sys_rst)
        begin
            rdata_nxt = '0;
            ack_nxt = 1'b0;
            pins_nxt = BCR1_CTRL_RESET; // [R03]
        end
    end

    always_ff @(posedge clk)
    begin
        rdata_r <= rdata_nxt;
        ack_r <= ack_nxt;
        pins_r <= pins_nxt;
    end

    assign bus_rdata = rdata_r;
    assign bus_ack = ack_r;
    assign cell_xcvr_enable_n = pins_r[0];
    assign cell_xcvr_reset_n = pins_r[1];
    assign phy_initial_enable_n = pins_r[2];
    assign phy_reset_n = pins_r[3];
    assign serial_a_xcvr_enable_n = pins_r[4];
    assign serial_b_xcvr_enable_n = pins_r[5];
endmodule

// ===== bcr1_assertions.sv
// Checker for board control register one bus and pin timing
`timescale 1ns/1ps
module bcr1_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic window_cs_n,
    input wire logic window_disable,
    input wire logic bus_we,
    input wire logic bus_re,
    input wire logic [2:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic host_hard_reset_n,
    input wire logic cell_xcvr_enable_n,
    input wire logic cell_xcvr_reset_n,
    input wire logic phy_reset_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Access accepted at this edge
    wire taken = !window_cs_n && !window_disable && bus_addr == 3'h1 && (bus_we || bus_re);
    sequence s_write;
        taken && bus_we;
    endsequence
    sequence s_host_low;
        !host_hard_reset_n [*3];
    endsequence
    property p_ack; taken |=> bus_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack after access");
    property p_noack; !taken |=> !bus_ack; endproperty
    a_noack: assert property (p_noack) else $error("ack without access");
    property p_zero; bus_ack |-> bus_rdata[23:0] == 24'h0; endproperty
    a_zero: assert property (p_zero) else $error("unused bits not zero");
    property p_hold; !(taken && !bus_we) |=> $stable(bus_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_host; s_host_low |=> !cell_xcvr_reset_n && !phy_reset_n; endproperty
    a_host: assert property (p_host) else $error("host reset not forced");
    property p_wr; s_write |-> ##2 cell_xcvr_enable_n == $past(bus_wdata[29], 2); endproperty
    a_wr: assert property (p_wr) else $error("enable pin not written");
    property p_def; disable iff (1'b0) sys_rst [*2] |=> cell_xcvr_enable_n && !bus_ack; endproperty
    a_def: assert property (p_def) else $error("reset default wrong");
    property p_rel; $rose(cell_xcvr_reset_n) |-> $past(host_hard_reset_n); endproperty
    a_rel: assert property (p_rel) else $error("reset released under host reset");
endmodule
bind bcr1_top bcr1_checker u_checker (.*);

// ===== bcr1_host_model.sv
// Host memory-controller model driving the board register window
`timescale 1ns/1ps
module bcr1_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic dis,
    output logic we,
    output logic re,
    output logic [2:0] addr,
    output logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack
);
    initial {cs_n, dis, we, re, addr, wdata} = {4'h8, 3'h0, 32'h0};
    // Window disable level, changed only between accesses at a falling edge
    task automatic set_dis(input logic v);
        @(negedge clk);
        dis = v;
    endtask
    // One access cycle, answer taken one cycle later; released data is inverted
    task automatic xfer(input logic c, input logic w, input logic [2:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic k);
        @(negedge clk);
        {cs_n, we, re, addr, wdata} = {c, w, !w, a, d};
        @(negedge clk);
        {k, q} = {ack, rdata};
        {cs_n, we, re, wdata} = {3'h4, ~d};
    endtask
endmodule

// ===== board_control_register_one_tb.sv
// Testbench for board control register one
`timescale 1ns/1ps
module board_control_register_one_tb;
    logic clk = 1'b0, sys_rst = 1'b1, cfg = 1'b0, swap = 1'b1, host_n = 1'b1, k;
    logic cs_n, dis, we, re, ack;
    logic [2:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [5:0] pins, f;
    int miscompares = 0, tests_run = 0, cyc = 0;
    bcr1_host_model host (.clk(clk), .cs_n(cs_n), .dis(dis), .we(we), .re(re), .addr(addr), .wdata(wdata),
        .rdata(rdata), .ack(ack));
    bcr1_top dut (.clk(clk), .sys_rst(sys_rst), .window_cs_n(cs_n), .window_disable(dis), .bus_we(we),
        .bus_re(re), .bus_addr(addr), .bus_wdata(wdata), .bus_rdata(rdata), .bus_ack(ack),
        .config_source_jumper(cfg), .boot_select_swap(swap), .host_hard_reset_n(host_n),
        .cell_xcvr_enable_n(pins[5]), .cell_xcvr_reset_n(pins[4]), .phy_initial_enable_n(pins[3]),
        .phy_reset_n(pins[2]), .serial_a_xcvr_enable_n(pins[1]), .serial_b_xcvr_enable_n(pins[0]));
    // Clock and hang limit
    initial forever #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            give_verdict;
        end
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        if (got !== exp)
            miscompares++;
    endtask
    // Read the register and compare ack and data
    task automatic rd(input logic [31:0] exp);
        host.xfer(1'b0, 1'b0, 3'h1, 32'h0, q, k);
        chk({31'h0, k}, 32'h1);
        chk(q, exp);
    endtask
    task automatic t_defaults;
        rd({cfg, swap, 6'h3f, 24'h0});
        chk({26'h0, pins}, 32'h3f);
        @(negedge clk);
        {cfg, swap} = 2'b10;
        repeat (3) @(negedge clk);
        rd(32'hbf000000);
        $display("defaults done");
    endtask
    task automatic t_fields;
        for (int i = 0; i < 6; i++)
        begin
            f = 6'h3f ^ (6'h20 >> i);
            host.xfer(1'b0, 1'b1, 3'h1, {2'b11, f, 24'hffffff}, q, k);
            chk({31'h0, k}, 32'h1);
            rd({cfg, swap, f, 24'h0});
            chk({26'h0, pins}, {26'h0, f});
        end
        $display("fields done");
    endtask
    task automatic t_refuse;
        host.xfer(1'b1, 1'b1, 3'h1, 32'h0, q, k);
        chk({31'h0, k}, 32'h0);
        host.set_dis(1'b1);
        host.xfer(1'b0, 1'b1, 3'h1, 32'h0, q, k);
        host.set_dis(1'b0);
        chk({31'h0, k}, 32'h0);
        host.xfer(1'b0, 1'b1, 3'h5, 32'h0, q, k);
        chk({31'h0, k}, 32'h0);
        rd({cfg, swap, f, 24'h0});
        $display("refuse done");
    endtask
    task automatic t_host;
        @(negedge clk);
        host_n = 1'b0;
        repeat (4) @(negedge clk);
        chk({26'h0, pins}, {26'h0, f & 6'h2b});
        host_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({26'h0, pins}, {26'h0, f});
        $display("host reset done");
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        t_defaults;
        t_fields;
        t_refuse;
        t_host;
        give_verdict;
    end
endmodule
